// File: dsfm_top.sv
// discharge switch fault mask: decides which faults drop the discharge switch
// assumes synchronous fault and current inputs, apb master on core_clk
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - set mask bit turns discharge switch off
// - mask a layout, reset E4
// - other mask a values may delay turn-off
// - mask b layout, reset E6
// - mask c layout, reset E2
// - discharge reverse current: charge on, precharge off
// - charge reverse current: discharge on unless a fault holds it off, predischarge off
// - parallel arrangement disables reverse handling
module dsfm_top #(
  parameter int NORMAL_DELAY = dsfm_pkg::NORMAL_DELAY_CYC,  // deferred turn-off, normal
  parameter int SLEEP_DELAY  = dsfm_pkg::SLEEP_DELAY_CYC    // deferred turn-off, sleep
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // fault detectors
  input  wire logic        short_circuit_discharge,
  input  wire logic        discharge_overcurrent_tier1,
  input  wire logic        discharge_overcurrent_tier2,
  input  wire logic        discharge_overcurrent_tier3,
  input  wire logic        cell_undervoltage,
  input  wire logic        switch_overtemperature,
  input  wire logic        internal_overtemperature,
  input  wire logic        discharge_overtemperature,
  input  wire logic        internal_undertemperature,
  input  wire logic        discharge_undertemperature,
  input  wire logic        short_circuit_latched,
  input  wire logic        discharge_overcurrent_latched,
  input  wire logic        host_watchdog_fault,
  input  wire logic        sleep_mode,
  // current measurement, signed ma, positive is charge
  input  wire logic [15:0] current_ma,
  // switch requests from the rest of the device
  input  wire logic        discharge_switch_req,
  input  wire logic        charge_switch_req,
  input  wire logic        predischarge_switch_req,
  input  wire logic        precharge_switch_req,
  // switch drivers
  output logic             discharge_switch,
  output logic             charge_switch,
  output logic             predischarge_switch,
  output logic             precharge_switch
);

  // ====================================================
  // register file
  logic [7:0]  mask_a_q;    // discharge switch mask a
  logic [7:0]  mask_b_q;    // discharge switch mask b
  logic [7:0]  mask_c_q;    // discharge switch mask c
  logic [15:0] thresh_q;    // reverse current threshold, ma
  logic        series_q;    // series switch option
  logic        pend_q;      // deferred turn-off in progress
  logic [31:0] dly_cnt_q;   // deferred turn-off counter

  wire logic wr_en = psel && penable && pwrite;  // single-cycle access phase

  // zero-wait slave, every access completes at once
  assign pready = 1'b1;

  // address outside the map answers with an error
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == dsfm_pkg::OFF_MASK_A) || (a == dsfm_pkg::OFF_MASK_B) ||
              (a == dsfm_pkg::OFF_MASK_C) || (a == dsfm_pkg::OFF_THRESH) ||
              (a == dsfm_pkg::OFF_CTRL)   || (a == dsfm_pkg::OFF_STATUS);
  endfunction : addr_ok

  assign pslverr = psel && penable && !addr_ok(paddr);

  // mask registers; reserved bits never store
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mask_a_q <= dsfm_pkg::RST_MASK_A;
      mask_b_q <= dsfm_pkg::RST_MASK_B;
      mask_c_q <= dsfm_pkg::RST_MASK_C;
    end else if (wr_en) begin
      if (paddr == dsfm_pkg::OFF_MASK_A) begin
        mask_a_q <= pwdata[7:0] & dsfm_pkg::VALID_A;
      end
      if (paddr == dsfm_pkg::OFF_MASK_B) begin
        mask_b_q <= pwdata[7:0] & dsfm_pkg::VALID_B;
      end
      if (paddr == dsfm_pkg::OFF_MASK_C) begin
        mask_c_q <= pwdata[7:0] & dsfm_pkg::VALID_C;
      end
    end
  end

  // threshold and option; threshold saturates at its ceiling
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thresh_q <= dsfm_pkg::RST_THRESH;
      series_q <= dsfm_pkg::RST_SERIES;
    end else if (wr_en) begin
      if (paddr == dsfm_pkg::OFF_THRESH) begin
        thresh_q <= (pwdata[15:0] > dsfm_pkg::MAX_THRESH) ? dsfm_pkg::MAX_THRESH : pwdata[15:0];
      end
      if (paddr == dsfm_pkg::OFF_CTRL) begin
        series_q <= pwdata[0];
      end
    end
  end

  // ====================================================
  // fault decision
  logic [7:0] flt_a;  // faults in mask a positions
  logic [7:0] flt_b;  // faults in mask b positions
  logic [7:0] flt_c;  // faults in mask c positions
  assign flt_a = {short_circuit_discharge, discharge_overcurrent_tier2, discharge_overcurrent_tier1,
                  2'b00, cell_undervoltage, 2'b00};
  assign flt_b = {switch_overtemperature, internal_overtemperature, discharge_overtemperature,
                  2'b00, internal_undertemperature, discharge_undertemperature, 1'b0};
  assign flt_c = {discharge_overcurrent_tier3, short_circuit_latched, discharge_overcurrent_latched,
                  3'b000, host_watchdog_fault, 1'b0};

  // reserved positions are zero in both operands
  wire logic hit_a = |(flt_a & mask_a_q);
  wire logic hit_b = |(flt_b & mask_b_q);
  wire logic hit_c = |(flt_c & mask_c_q);
  wire logic fast_a = (mask_a_q == dsfm_pkg::FAST_A0) || (mask_a_q == dsfm_pkg::FAST_A1);

  // mask a hits wait when its value is not a fast one; b and c act at once
  wire logic hit_now = hit_b || hit_c || (hit_a && fast_a);

  // deferred turn-off, bounded by the mode-dependent limit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_q    <= 1'b0;
      dly_cnt_q <= 32'h0000_0000;
    end else if (!hit_a || fast_a) begin
      pend_q    <= 1'b0;
      dly_cnt_q <= 32'h0000_0000;
    end else if (!pend_q) begin
      pend_q    <= 1'b1;
      dly_cnt_q <= sleep_mode ? SLEEP_DELAY[31:0] : NORMAL_DELAY[31:0];
    end else if (dly_cnt_q != 32'h0000_0000) begin
      dly_cnt_q <= dly_cnt_q - 32'h0000_0001;
    end
  end

  wire logic hit_late = pend_q && (dly_cnt_q == 32'h0000_0000);
  wire logic dsg_off  = hit_now || hit_late;

  // ====================================================
  // reverse current handling
  wire logic        is_dsg = current_ma[15];  // negative current = discharge
  logic [15:0]      mag;                       // current magnitude
  assign mag = is_dsg ? 16'(~current_ma + 16'h0001) : current_ma;

  wire logic rev_dsg = series_q && is_dsg && (mag > thresh_q) &&
                       (discharge_switch_req || predischarge_switch_req);
  wire logic rev_chg = series_q && !is_dsg && (mag > thresh_q) &&
                       (charge_switch_req || precharge_switch_req);

  // registered switch outputs; fault off beats reverse-current on
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      discharge_switch    <= 1'b0;
      charge_switch       <= 1'b0;
      predischarge_switch <= 1'b0;
      precharge_switch    <= 1'b0;
    end else begin
      discharge_switch    <= !dsg_off && (discharge_switch_req || rev_chg);
      predischarge_switch <= predischarge_switch_req && !rev_chg;
      charge_switch       <= charge_switch_req || rev_dsg;
      precharge_switch    <= precharge_switch_req && !rev_dsg;
    end
  end

  // ====================================================
  // read mux, registered
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        dsfm_pkg::OFF_MASK_A: prdata <= {24'h000000, mask_a_q};
        dsfm_pkg::OFF_MASK_B: prdata <= {24'h000000, mask_b_q};
        dsfm_pkg::OFF_MASK_C: prdata <= {24'h000000, mask_c_q};
        dsfm_pkg::OFF_THRESH: prdata <= {16'h0000, thresh_q};
        dsfm_pkg::OFF_CTRL:   prdata <= {31'h00000000, series_q};
        dsfm_pkg::OFF_STATUS: prdata <= {27'h0000000, pend_q, precharge_switch,
                                          predischarge_switch, charge_switch, discharge_switch};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ====================================================
  // checks
  AST_FAULT_B_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    hit_b |=> !discharge_switch) else $error("mask b fault left switch on");
  AST_FAULT_C_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    hit_c |=> !discharge_switch) else $error("mask c fault left switch on");
  AST_FAST_A: assert property (@(posedge core_clk) disable iff (sys_rst)
    (hit_a && fast_a) |=> !discharge_switch) else $error("fast mask a did not act");
  AST_MASK_A_RSV: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mask_a_q & ~dsfm_pkg::VALID_A) == 8'h00) else $error("mask a reserved bit set");
  AST_REV_DSG: assert property (@(posedge core_clk) disable iff (sys_rst)
    rev_dsg |=> (charge_switch && !precharge_switch)) else $error("discharge reverse failed");
  AST_REV_CHG: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rev_chg && !dsg_off) |=> (discharge_switch && !predischarge_switch)) else $error("charge reverse failed");
  AST_PARALLEL: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!series_q && !charge_switch_req) |=> !charge_switch) else $error("parallel mode turned switch on");
  AST_RESET_A: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> mask_a_q == dsfm_pkg::RST_MASK_A) else $error("mask a reset value");
  AST_RESET_BC: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> (mask_b_q == dsfm_pkg::RST_MASK_B && mask_c_q == dsfm_pkg::RST_MASK_C))
    else $error("mask b or c reset value");
  AST_NO_FAULT_NO_EFFECT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!hit_b && !hit_c && !hit_a && !pend_q && discharge_switch_req) |=> discharge_switch)
    else $error("switch off without fault");

  COV_FAULT_OFF: cover property (@(posedge core_clk) disable iff (sys_rst)
    discharge_switch ##1 !discharge_switch);
  COV_REV_DSG: cover property (@(posedge core_clk) disable iff (sys_rst) rev_dsg);
  COV_REV_CHG: cover property (@(posedge core_clk) disable iff (sys_rst) rev_chg);
  COV_DEFER: cover property (@(posedge core_clk) disable iff (sys_rst) pend_q ##1 hit_late);

endmodule : dsfm_top

`default_nettype wire

// File: dsfm_pkg.sv
// package for the discharge switch fault mask block
// assumes a 32-bit apb slave at word-aligned offsets
package dsfm_pkg;
  // ====================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_MASK_A  = 8'h00;  // discharge switch mask a
  localparam logic [7:0] OFF_MASK_B  = 8'h04;  // discharge switch mask b
  localparam logic [7:0] OFF_MASK_C  = 8'h08;  // discharge switch mask c
  localparam logic [7:0] OFF_THRESH  = 8'h0C;  // reverse current threshold
  localparam logic [7:0] OFF_CTRL    = 8'h10;  // series switch option
  localparam logic [7:0] OFF_STATUS  = 8'h14;  // switch state readback
  // ====================================================
  // reset values
  localparam logic [7:0]  RST_MASK_A = 8'hE4;
  localparam logic [7:0]  RST_MASK_B = 8'hE6;
  localparam logic [7:0]  RST_MASK_C = 8'hE2;
  localparam logic [15:0] RST_THRESH = 16'h0032;
  localparam logic [15:0] MAX_THRESH = 16'h7FFF;  // 32767 ma ceiling
  localparam logic        RST_SERIES = 1'b1;
  // ====================================================
  // writable bits of each mask; reserved bits are dropped
  localparam logic [7:0] VALID_A = 8'hE4;
  localparam logic [7:0] VALID_B = 8'hE6;
  localparam logic [7:0] VALID_C = 8'hE2;
  // mask a values that give immediate turn-off
  localparam logic [7:0] FAST_A0 = 8'h80;
  localparam logic [7:0] FAST_A1 = 8'hE4;
  // ====================================================
  // deferred turn-off timing
  localparam int NORMAL_DELAY_MS = 250;
  localparam int SLEEP_DELAY_MS  = 1000;
  localparam int CLK_KHZ         = 250000;
  localparam int NORMAL_DELAY_CYC = NORMAL_DELAY_MS * CLK_KHZ;
  localparam int SLEEP_DELAY_CYC  = SLEEP_DELAY_MS * CLK_KHZ;
  // status bit positions
  localparam int ST_DSG  = 0;
  localparam int ST_CHG  = 1;
  localparam int ST_PREDISCHARGE_SWITCH = 2;
  localparam int ST_PRECHARGE_SWITCH = 3;
  localparam int ST_PEND = 4;
endpackage : dsfm_pkg

// File: dsfm_switch_model.sv
// partner model: gate drivers behind the four switch outputs
// assumes registered switch commands on core_clk, high means on
`timescale 1ns/1ps
`default_nettype none
module dsfm_switch_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] sw_cmd,  // dsg, chg, predischarge_switch, precharge_switch
  output logic      [3:0] gate_q   // gate levels seen by the pack
);
  // ==========
  // gates lag commands one edge, as a driver stage would
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_q <= 4'h0;  // all gates off in reset
    end else begin
      gate_q <= sw_cmd;
    end
  end
endmodule : dsfm_switch_model
`default_nettype wire

// File: dsfm_top_bench.sv
// testbench for dsfm_top: apb register tests, fault masks, reverse current
// assumes short defer parameters so the delayed turn-off fits the run
`timescale 1ns/1ps
`default_nettype none
module dsfm_top_bench;
  localparam int ND = 8;   // short normal defer
  localparam int SD = 16;  // short sleep defer
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err_q;
  logic [12:0] flt = 13'h0;  // faults, msb short circuit
  logic        sleep_mode = 1'b0;
  logic [15:0] current_ma = 16'h0;
  logic [3:0]  req = 4'h0, sw, gate;  // dsg, chg, predischarge_switch, precharge_switch
  int          err_total = 0, compares = 0, cyc = 0, n;
  int          bp[13] = '{1, 5, 6, 7, 1, 2, 5, 6, 7, 2, 5, 6, 7};  // mask bit per fault
  logic [7:0]  ma;
  logic [31:0] dv;
  logic [3:0]  rq[7] = '{4'h9, 4'h9, 4'h3, 4'h6, 4'h3, 4'h9, 4'h6};
  logic [3:0]  ex[7] = '{4'hC, 4'h9, 4'h6, 4'hC, 4'h9, 4'h9, 4'h6};
  logic [15:0] cu[7] = '{16'hFFCD, 16'hFFCE, 16'hFFCD, 16'h0033, 16'h0033, 16'hFFCD, 16'h0033};
  dsfm_top #(.NORMAL_DELAY(ND), .SLEEP_DELAY(SD)) uut (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .short_circuit_discharge(flt[12]), .discharge_overcurrent_tier2(flt[11]),
    .discharge_overcurrent_tier1(flt[10]), .cell_undervoltage(flt[9]), .switch_overtemperature(flt[8]),
    .internal_overtemperature(flt[7]), .discharge_overtemperature(flt[6]),
    .internal_undertemperature(flt[5]), .discharge_undertemperature(flt[4]),
    .discharge_overcurrent_tier3(flt[3]), .short_circuit_latched(flt[2]),
    .discharge_overcurrent_latched(flt[1]), .host_watchdog_fault(flt[0]), .sleep_mode, .current_ma,
    .discharge_switch_req(req[3]), .charge_switch_req(req[2]), .predischarge_switch_req(req[1]),
    .precharge_switch_req(req[0]), .discharge_switch(sw[3]), .charge_switch(sw[2]),
    .predischarge_switch(sw[1]), .precharge_switch(sw[0]));
  dsfm_switch_model drv (.core_clk, .sys_rst, .sw_cmd(sw), .gate_q(gate));
  // ==========
  // clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin  // about ten times the expected run
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      ma = 8'(4 * j);
      dv = (j == 0) ? 32'hE4 : (j == 1) ? 32'hE6 : 32'hE2;
      apb(1'b0, ma, 32'h0); chk("mask_reset", dv, rd_q);
      apb(1'b1, ma, 32'hFF); apb(1'b0, ma, 32'h0); chk("mask_reserved", dv, rd_q);
    end
    apb(1'b0, dsfm_pkg::OFF_THRESH, 32'h0); chk("thresh_reset", 32'h32, rd_q);
    apb(1'b1, dsfm_pkg::OFF_THRESH, 32'hFFFF); apb(1'b0, dsfm_pkg::OFF_THRESH, 32'h0);
    chk("thresh_max", 32'h7FFF, rd_q);
    apb(1'b1, dsfm_pkg::OFF_THRESH, 32'h32);
    apb(1'b0, dsfm_pkg::OFF_CTRL, 32'h0); chk("series_reset", 32'h1, rd_q);
    apb(1'b0, 8'h20, 32'h0); chk("unmapped_data", 32'h0, rd_q);
    chk("unmapped_err", 32'h1, {31'h0, err_q});
    $display("test registers done");
    req <= 4'hF;
    for (int i = 0; i < 13; i++) begin
      ma = (i < 4) ? dsfm_pkg::OFF_MASK_C : (i < 9) ? dsfm_pkg::OFF_MASK_B : dsfm_pkg::OFF_MASK_A;
      dv = (i < 4) ? 32'hE2 : (i < 9) ? 32'hE6 : 32'hE4;
      @(posedge core_clk) flt <= 13'h1 << i;
      @(posedge core_clk) #1 chk("dsg_masked_on", 32'h0, {31'h0, sw[3]});
      @(posedge core_clk) flt <= 13'h0;
      apb(1'b1, ma, dv & ~(32'h1 << bp[i]));
      @(posedge core_clk) flt <= 13'h1 << i;
      repeat (SD + 3) @(posedge core_clk);
      #1 chk("dsg_masked_off", 32'h1, {31'h0, sw[3]});
      @(posedge core_clk) flt <= 13'h0;
      apb(1'b1, ma, dv);
    end
    $display("test fault masks done");
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, dsfm_pkg::OFF_MASK_A, 32'h24);
      @(posedge core_clk) begin sleep_mode <= s[0]; flt <= 13'h400; end
      n = 0;
      do begin @(posedge core_clk); #1; n++; end while (sw[3] !== 1'b0 && n < 40);
      chk("defer_bound", 32'h1, {31'h0, n <= ((s == 1) ? SD : ND) + 2});
      @(posedge core_clk) flt <= 13'h0;
      apb(1'b1, dsfm_pkg::OFF_MASK_A, 32'h80);
      @(posedge core_clk) flt <= 13'h1000;
      @(posedge core_clk) #1 chk("dsg_fast", 32'h0, {31'h0, sw[3]});
      @(posedge core_clk) begin flt <= 13'h0; sleep_mode <= 1'b0; end
    end
    apb(1'b1, dsfm_pkg::OFF_MASK_A, 32'hE4);
    $display("test deferral done");
    for (int k = 0; k < 7; k++) begin
      if (k == 5) apb(1'b1, dsfm_pkg::OFF_CTRL, 32'h0);
      @(posedge core_clk) begin req <= rq[k]; current_ma <= cu[k]; end
      repeat (2) @(posedge core_clk);
      #1 chk("switches", {28'h0, ex[k]}, {28'h0, sw});
      @(posedge core_clk) #1 chk("gates", {28'h0, ex[k]}, {28'h0, gate});
    end
    apb(1'b0, dsfm_pkg::OFF_STATUS, 32'h0); chk("status", 32'h6, rd_q);
    $display("test reverse current done");
    summarize();
  end
endmodule : dsfm_top_bench
`default_nettype wire
